/* File: design/smac_acc_upper.sv */
`timescale 1ns/1ns
`include "smac_map.svh"

module smac_acc_upper
	import smac_pkg::*;
(
	// Clock and reset
	input  logic        mclk,
	input  logic        srst,
	// From the low half adder
	input  logic        start,
	input  logic        carry_in,
	input  logic        sign_in,
	input  logic        clear,
	// Upper half state
	output logic [15:0] acc_hi,
	output logic        pending
);

	smac_hi_e    hi_state_r;
	smac_hi_e    hi_state_nxt;
	logic        carry_r;
	logic        carry_nxt;
	logic        sign_r;
	logic        sign_nxt;
	logic [15:0] acc_hi_r;
	logic [15:0] acc_hi_nxt;

	// Upper half settles one cycle after the low half; shorter add path per cycle
	always_comb
	begin
		hi_state_nxt = hi_state_r;
		carry_nxt    = carry_r;
		sign_nxt     = sign_r;
		acc_hi_nxt   = acc_hi_r;
		case (hi_state_r)
			SMAC_HI_IDLE: hi_state_nxt = SMAC_HI_IDLE;
			SMAC_HI_PEND:
			begin
				acc_hi_nxt   = acc_hi_r + {16{sign_r}} + {15'h0000, carry_r};
				hi_state_nxt = SMAC_HI_IDLE;
			end
			default: hi_state_nxt = SMAC_HI_IDLE;
		endcase
		if (start)
		begin
			carry_nxt    = carry_in;
			sign_nxt     = sign_in;
			hi_state_nxt = SMAC_HI_PEND;
		end
		if (clear)
		begin
			acc_hi_nxt   = `SMAC_RST_HALF;
			hi_state_nxt = SMAC_HI_IDLE;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			hi_state_r <= SMAC_HI_IDLE;
			carry_r    <= 1'b0;
			sign_r     <= 1'b0;
			acc_hi_r   <= `SMAC_RST_HALF;
		end
		else
		begin
			hi_state_r <= hi_state_nxt;
			carry_r    <= carry_nxt;
			sign_r     <= sign_nxt;
			acc_hi_r   <= acc_hi_nxt;
		end
	end

	assign acc_hi  = acc_hi_r;
	assign pending = (hi_state_r == SMAC_HI_PEND);

endmodule : smac_acc_upper

/* File: design/smac_top.sv */
`timescale 1ns/1ns
`include "smac_map.svh"

// Operation
// - All four operand inputs are 8-bit signed two's complement values.
// - Product is 16-bit signed, high byte and low byte readable separately.
// - Accumulator is 32-bit signed, byte 0 lowest through byte 3 highest.
// - Writing a multiply-only operand recomputes the product, accumulator untouched.
// - Writing an accumulate operand multiplies and adds product into accumulator.
// - One shared X and one shared Y operand serve both functions.
// - Any write to either clear address zeroes all four accumulator bytes.
// - Product and low accumulator bytes valid at once; upper bytes one later.
// - Multiply-only writes and product reads work back to back.
// - Multiply X input is 8-bit write-only, resets to zero.
// - Accumulate and clear addresses read back accumulator bytes.
module smac_top
	import smac_pkg::*;
(
	// Clock and reset
	input  logic      mclk,
	input  logic      srst,
	// CPU register bus
	input  smac_req_s bus_req,
	output smac_rsp_s bus_rsp
);

	function automatic logic smac_hit(input smac_req_s r, input logic [7:0] off);
		smac_hit = (r.bank == `SMAC_BANK_MAC) && (r.addr == off);
	endfunction : smac_hit

	// Write decode
	logic        wr_multiply_x_operand;
	logic        wr_y_operand_multiply_only;
	logic        wr_x_operand_accumulate;
	logic        wr_y_operand_accumulate;
	logic        wr_clr;
	logic        wr_mac;
	logic        wr_opnd;

	// Operands and results
	logic [7:0]         x_r;
	logic [7:0]         x_nxt;
	logic [7:0]         y_r;
	logic [7:0]         y_nxt;
	logic signed [15:0] prod_full;
	logic [15:0]        prod_r;
	logic [15:0]        prod_nxt;
	logic [16:0]        sum_lo;
	logic [15:0]        acc_lo_r;
	logic [15:0]        acc_lo_nxt;
	logic [15:0]        acc_hi;
	logic               hi_pend;
	logic [31:0]        acc_all;
	logic [7:0]         acc_byte [4];

	// Read answer
	smac_rsp_s   rsp_r;
	smac_rsp_s   rsp_nxt;

	always_comb
	begin
		wr_multiply_x_operand = bus_req.wr && smac_hit(bus_req, `SMAC_OFF_MULTIPLY_X_OPERAND);
		wr_y_operand_multiply_only = bus_req.wr && smac_hit(bus_req, `SMAC_OFF_Y_OPERAND_MULTIPLY_ONLY);
		wr_x_operand_accumulate = bus_req.wr && smac_hit(bus_req, `SMAC_OFF_X_OPERAND_ACCUMULATE);
		wr_y_operand_accumulate = bus_req.wr && smac_hit(bus_req, `SMAC_OFF_Y_OPERAND_ACCUMULATE);
		wr_clr   = bus_req.wr && (smac_hit(bus_req, `SMAC_OFF_CLR_A) ||
			smac_hit(bus_req, `SMAC_OFF_CLR_B));
		wr_mac   = wr_x_operand_accumulate || wr_y_operand_accumulate;
		wr_opnd  = wr_multiply_x_operand || wr_y_operand_multiply_only || wr_mac;
	end

	// Datapath: either X address feeds the same X, likewise for Y
	always_comb
	begin
		x_nxt = (wr_multiply_x_operand || wr_x_operand_accumulate) ? bus_req.wdata : x_r;
		y_nxt = (wr_y_operand_multiply_only || wr_y_operand_accumulate) ? bus_req.wdata : y_r;
		// New operand is used in the same cycle, so product and low accumulator never lag a write
		prod_full = $signed(x_nxt) * $signed(y_nxt);
		prod_nxt  = wr_opnd ? prod_full : prod_r;
		sum_lo    = {1'b0, acc_lo_r} + {1'b0, prod_full};
		acc_lo_nxt = acc_lo_r;
		if (wr_clr)
			acc_lo_nxt = `SMAC_RST_HALF;
		else if (wr_mac)
			acc_lo_nxt = sum_lo[15:0];
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			x_r      <= `SMAC_RST_BYTE;
			y_r      <= `SMAC_RST_BYTE;
			prod_r   <= `SMAC_RST_HALF;
			acc_lo_r <= `SMAC_RST_HALF;
		end
		else
		begin
			x_r      <= x_nxt;
			y_r      <= y_nxt;
			prod_r   <= prod_nxt;
			acc_lo_r <= acc_lo_nxt;
		end
	end

	// Upper half takes the carry and sign one cycle later
	smac_acc_upper u_upper
	(
		.mclk     (mclk),
		.srst     (srst),
		.start    (wr_mac),
		.carry_in (sum_lo[16]),
		.sign_in  (prod_full[`SMAC_PROD_SIGN]),
		.clear    (wr_clr),
		.acc_hi   (acc_hi),
		.pending  (hi_pend)
	);

	assign acc_all = {acc_hi, acc_lo_r};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_acc_byte
			assign acc_byte[gi] = acc_all[gi*8 +: 8];
		end
	endgenerate

	// Read path; input-only addresses and foreign addresses read zero.
	// Upper bytes read during the settle cycle show the old value.
	always_comb
	begin
		rsp_nxt.valid = bus_req.rd;
		rsp_nxt.data  = `SMAC_RD_NONE;
		if (bus_req.rd && bus_req.bank == `SMAC_BANK_MAC)
		begin
			case (bus_req.addr)
				`SMAC_OFF_PROD_HI: rsp_nxt.data = prod_r[15:8];
				`SMAC_OFF_PROD_LO: rsp_nxt.data = prod_r[7:0];
				`SMAC_OFF_X_OPERAND_ACCUMULATE:   rsp_nxt.data = acc_byte[1];
				`SMAC_OFF_Y_OPERAND_ACCUMULATE:   rsp_nxt.data = acc_byte[0];
				`SMAC_OFF_CLR_A:   rsp_nxt.data = acc_byte[3];
				`SMAC_OFF_CLR_B:   rsp_nxt.data = acc_byte[2];
				default:           rsp_nxt.data = `SMAC_RD_NONE;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			rsp_r <= '0;
		else
			rsp_r <= rsp_nxt;
	end

	assign bus_rsp = rsp_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	chk_prod_signed: assert property (
		wr_multiply_x_operand |=> $signed(prod_r) == $signed($past(bus_req.wdata)) * $signed(y_r))
		else $error("product of signed operands wrong");

	chk_mul_keeps_acc: assert property (
		(wr_multiply_x_operand || wr_y_operand_multiply_only) && !hi_pend |=> $stable(acc_lo_r) && $stable(acc_hi))
		else $error("multiply-only write changed accumulator");

	chk_mac_low_now: assert property (
		wr_mac |=> acc_lo_r == 16'($past(acc_lo_r) + prod_r))
		else $error("low accumulator not updated after accumulate write");

	chk_mac_full_sum: assert property (
		wr_mac && !hi_pend ##1 !bus_req.wr |=>
			acc_all == $past(acc_all, 2) + {{16{$past(prod_r[15])}}, $past(prod_r)})
		else $error("32-bit accumulate sum wrong");

	chk_shared_x: assert property (
		wr_x_operand_accumulate ##1 wr_y_operand_multiply_only |=> prod_r == 16'($signed($past(x_r)) * $signed(y_r)))
		else $error("accumulate X not shared with multiply");

	chk_clear_all: assert property (
		wr_clr |=> acc_all == 32'h0000_0000 && !hi_pend)
		else $error("clear did not zero accumulator");

	chk_upper_lag: assert property (
		wr_mac ##1 !bus_req.wr |-> hi_pend ##1 !hi_pend)
		else $error("upper accumulator not settled one cycle later");

	chk_mul_read_b2b: assert property (
		wr_y_operand_multiply_only ##1 (bus_req.rd && smac_hit(bus_req, `SMAC_OFF_PROD_LO)) |=>
			rsp_r.valid && rsp_r.data == 8'($signed($past(x_r, 2)) * $signed($past(y_r))))
		else $error("back-to-back product read wrong");

	chk_mulx_wo: assert property (
		bus_req.rd && smac_hit(bus_req, `SMAC_OFF_MULTIPLY_X_OPERAND) |=> rsp_r.data == `SMAC_RD_NONE)
		else $error("write-only X input read non-zero");

	chk_acc_read_port: assert property (
		bus_req.rd && smac_hit(bus_req, `SMAC_OFF_CLR_A) |=> rsp_r.data == $past(acc_all[31:24]))
		else $error("clear address did not read top accumulator byte");

	chk_prod_hi_read: assert property (
		bus_req.rd && smac_hit(bus_req, `SMAC_OFF_PROD_HI) |=>
			rsp_r.valid && rsp_r.data == $past(prod_r[15:8]))
		else $error("product high byte read wrong");

	chk_prod_lo_read: assert property (
		bus_req.rd && smac_hit(bus_req, `SMAC_OFF_PROD_LO) |=>
			rsp_r.valid && rsp_r.data == $past(prod_r[7:0]))
		else $error("product low byte read wrong");

	chk_acc_b0_read: assert property (
		bus_req.rd && smac_hit(bus_req, `SMAC_OFF_Y_OPERAND_ACCUMULATE) |=>
			rsp_r.valid && rsp_r.data == $past(acc_all[7:0]))
		else $error("accumulate Y address did not read byte 0");

	chk_acc_b1_read: assert property (
		bus_req.rd && smac_hit(bus_req, `SMAC_OFF_X_OPERAND_ACCUMULATE) |=>
			rsp_r.valid && rsp_r.data == $past(acc_all[15:8]))
		else $error("accumulate X address did not read byte 1");

	chk_acc_b2_read: assert property (
		bus_req.rd && smac_hit(bus_req, `SMAC_OFF_CLR_B) |=>
			rsp_r.valid && rsp_r.data == $past(acc_all[23:16]))
		else $error("second clear address did not read byte 2");

	chk_muly_wo: assert property (
		bus_req.rd && smac_hit(bus_req, `SMAC_OFF_Y_OPERAND_MULTIPLY_ONLY) |=>
			rsp_r.valid && rsp_r.data == `SMAC_RD_NONE)
		else $error("write-only Y input read non-zero");

	chk_foreign_rd: assert property (
		bus_req.rd && bus_req.bank != `SMAC_BANK_MAC |=>
			rsp_r.valid && rsp_r.data == `SMAC_RD_NONE)
		else $error("read of another bank returned data");

	chk_rd_answer: assert property (
		1'b1 |=> rsp_r.valid == $past(bus_req.rd))
		else $error("read answer not exactly one cycle after strobe");

	// Holds and loads: a strobe aimed elsewhere must leave every register alone, its own strobe must load it
	chk_x_hold: assert property (
		!(wr_multiply_x_operand || wr_x_operand_accumulate) |=> $stable(x_r))
		else $error("X operand changed without an X write");

	chk_y_hold: assert property (
		!(wr_y_operand_multiply_only || wr_y_operand_accumulate) |=> $stable(y_r))
		else $error("Y operand changed without a Y write");

	chk_x_load: assert property (
		wr_multiply_x_operand || wr_x_operand_accumulate |=> x_r == $past(bus_req.wdata))
		else $error("X write not loaded into shared X");

	chk_y_load: assert property (
		wr_y_operand_multiply_only || wr_y_operand_accumulate |=> y_r == $past(bus_req.wdata))
		else $error("Y write not loaded into shared Y");

	chk_prod_hold: assert property (
		!wr_opnd |=> $stable(prod_r))
		else $error("product changed without an operand write");

	chk_prod_follows: assert property (
		wr_opnd |=> prod_r == 16'($signed(x_r) * $signed(y_r)))
		else $error("product does not match current operands");

	chk_lo_hold: assert property (
		!wr_mac && !wr_clr |=> $stable(acc_lo_r))
		else $error("low accumulator changed without accumulate or clear");

	chk_hi_hold: assert property (
		!hi_pend && !wr_clr |=> $stable(acc_hi))
		else $error("upper accumulator changed outside its settle cycle");

	chk_hi_one_step: assert property (
		wr_mac |=> hi_pend)
		else $error("upper accumulator update not scheduled");

	chk_pend_ends: assert property (
		hi_pend && !wr_mac |=> !hi_pend)
		else $error("upper accumulator pending for more than one cycle");

	chk_bank_filter: assert property (
		bus_req.wr && bus_req.bank != `SMAC_BANK_MAC |=>
			$stable(x_r) && $stable(y_r) && $stable(acc_lo_r))
		else $error("write to another bank changed the unit");

	chk_clr_keeps_opnd: assert property (
		wr_clr |=> $stable(x_r) && $stable(y_r) && $stable(prod_r))
		else $error("clear disturbed operands or product");

	// Main scenarios
	cov_mac_then_clear: cover property (wr_mac ##2 wr_clr);
	cov_neg_product: cover property (wr_mac && prod_full[`SMAC_PROD_SIGN]);
	cov_two_macs: cover property (wr_mac ##2 wr_mac);
	cov_shared_x: cover property (wr_x_operand_accumulate ##1 wr_y_operand_multiply_only);
	cov_foreign_wr: cover property (bus_req.wr && bus_req.bank != `SMAC_BANK_MAC);

endmodule : smac_top

/* File: include/smac_map.svh */
`ifndef SMAC_MAP_SVH
`define SMAC_MAP_SVH

// Register bank holding the unit
`define SMAC_BANK_MAC    1'b0

// Register offsets within the bank
`define SMAC_OFF_MULTIPLY_X_OPERAND   8'hE8
`define SMAC_OFF_Y_OPERAND_MULTIPLY_ONLY   8'hE9
`define SMAC_OFF_PROD_HI 8'hEA
`define SMAC_OFF_PROD_LO 8'hEB
`define SMAC_OFF_X_OPERAND_ACCUMULATE   8'hEC
`define SMAC_OFF_Y_OPERAND_ACCUMULATE   8'hED
`define SMAC_OFF_CLR_A   8'hEE
`define SMAC_OFF_CLR_B   8'hEF

// Field positions
`define SMAC_PROD_SIGN   15
`define SMAC_HALF_W      16

// Reset and read-back values
`define SMAC_RST_BYTE    8'h00
`define SMAC_RST_HALF    16'h0000
`define SMAC_RD_NONE     8'h00

// Upper accumulator lag in mclk cycles
`define SMAC_HI_LAG_CYC  1

`endif

/* File: include/smac_pkg.sv */
package smac_pkg;

	// One CPU bus cycle toward the unit
	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic       bank;
		logic [7:0] addr;
		logic [7:0] wdata;
	} smac_req_s;

	// Read answer
	typedef struct packed
	{
		logic       valid;
		logic [7:0] data;
	} smac_rsp_s;

	// Upper accumulator half stage
	typedef enum logic [1:0]
	{
		SMAC_HI_IDLE = 2'h1,
		SMAC_HI_PEND = 2'h2
	} smac_hi_e;

endpackage : smac_pkg

/* File: test/smac_cpu_model.sv */
`timescale 1ns/1ns
`include "smac_map.svh"

module smac_cpu_model
	import smac_pkg::*;
(
	// Clock
	input  logic      mclk,
	// Register bus
	output smac_req_s req,
	input  smac_rsp_s rsp
);
	initial req = '0;

	// Request held across one rising edge; the answer is sampled one cycle on
	task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d,
		output smac_rsp_s r);
		req = '{wr: w, rd: !w, bank: `SMAC_BANK_MAC, addr: a, wdata: d};
		@(negedge mclk);
		r = rsp;
	endtask : op

	// Same bus cycle as op, aimed at the other bank
	task automatic op_other(input logic w, input logic [7:0] a, input logic [7:0] d,
		output smac_rsp_s r);
		req = '{wr: w, rd: !w, bank: !`SMAC_BANK_MAC, addr: a, wdata: d};
		@(negedge mclk);
		r = rsp;
	endtask : op_other

	// Spare cycle so the upper accumulator half can settle
	task automatic idle();
		req = '0;
		@(negedge mclk);
	endtask : idle
endmodule : smac_cpu_model

/* File: test/testbench.sv */
`timescale 1ns/1ns
`include "smac_map.svh"

module testbench
	import smac_pkg::*;
;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	smac_req_s   bus_req;
	smac_rsp_s   bus_rsp;
	smac_rsp_s   r;
	int          num_errors = 0;
	int          check_count = 0;
	logic [31:0] rows [6] = '{32'h7F7F3F01, 32'h80804000, 32'h807FC080,
		32'hFF01FFFF, 32'h005A0000, 32'hFE03FFFA};
	logic [7:0]  clr [2] = '{`SMAC_OFF_CLR_A, `SMAC_OFF_CLR_B};

	always #20 mclk = ~mclk;

	smac_top smac_top_i (.mclk(mclk), .srst(srst), .bus_req(bus_req), .bus_rsp(bus_rsp));
	smac_cpu_model smac_cpu_model_i (.mclk(mclk), .req(bus_req), .rsp(bus_rsp));

	task automatic print_verdict();
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task automatic cmp_rd(input logic [7:0] exp);
		check_count++;
		if (r.valid !== 1'b1 || r.data !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t read %h/%h want %h", $time, r.valid, r.data, exp);
		end
	endtask : cmp_rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		smac_cpu_model_i.op(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		smac_cpu_model_i.op(1'b0, a, 8'h00, r);
		cmp_rd(exp);
	endtask : rd

	// Upper bytes last, so they are read well after any accumulate
	task automatic rd_acc(input logic [31:0] exp);
		rd(`SMAC_OFF_Y_OPERAND_ACCUMULATE, exp[7:0]);
		rd(`SMAC_OFF_X_OPERAND_ACCUMULATE, exp[15:8]);
		rd(`SMAC_OFF_CLR_B, exp[23:16]);
		rd(`SMAC_OFF_CLR_A, exp[31:24]);
	endtask : rd_acc

	// Hang guard
	initial
	begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		print_verdict();
	end

	initial
	begin
		repeat (5) @(negedge mclk);
		srst = 1'b0;
		for (int a = 'hE8; a <= 'hEF; a++)
			rd(8'(a), `SMAC_RST_BYTE);
		foreach (rows[i])
		begin
			wr(`SMAC_OFF_MULTIPLY_X_OPERAND, rows[i][31:24]);
			wr(`SMAC_OFF_Y_OPERAND_MULTIPLY_ONLY, rows[i][23:16]);
			rd(`SMAC_OFF_PROD_HI, rows[i][15:8]);
			rd(`SMAC_OFF_PROD_LO, rows[i][7:0]);
		end
		rd_acc(32'h00000000);
		wr(`SMAC_OFF_CLR_A, 8'h5A);
		wr(`SMAC_OFF_MULTIPLY_X_OPERAND, 8'h80);
		wr(`SMAC_OFF_Y_OPERAND_ACCUMULATE, 8'h80);
		rd_acc(32'h00004000);
		for (int k = 0; k < 2; k++)
		begin
			wr(`SMAC_OFF_Y_OPERAND_ACCUMULATE, 8'h7F);
			smac_cpu_model_i.idle();
		end
		rd_acc(32'hFFFFC100);
		wr(`SMAC_OFF_MULTIPLY_X_OPERAND, 8'h02);
		rd(`SMAC_OFF_PROD_LO, 8'hFE);
		rd(`SMAC_OFF_PROD_HI, 8'h00);
		rd_acc(32'hFFFFC100);
		foreach (clr[i])
		begin
			wr(`SMAC_OFF_X_OPERAND_ACCUMULATE, 8'h80);
			smac_cpu_model_i.idle();
			wr(clr[i], 8'hFF);
			rd_acc(32'h00000000);
		end
		rd(`SMAC_OFF_PROD_HI, 8'hC0);
		rd(`SMAC_OFF_PROD_LO, 8'h80);
		// Other bank: writes ignored, reads answer 00
		smac_cpu_model_i.op_other(1'b1, `SMAC_OFF_MULTIPLY_X_OPERAND, 8'h11, r);
		smac_cpu_model_i.op_other(1'b0, `SMAC_OFF_PROD_LO, 8'h00, r);
		cmp_rd(`SMAC_RD_NONE);
		rd(`SMAC_OFF_PROD_LO, 8'h80);
		// X through the accumulate input, Y through multiply-only, product read at once
		wr(`SMAC_OFF_X_OPERAND_ACCUMULATE, 8'h03);
		wr(`SMAC_OFF_Y_OPERAND_MULTIPLY_ONLY, 8'hFB);
		rd(`SMAC_OFF_PROD_LO, 8'hF1);
		rd(`SMAC_OFF_PROD_HI, 8'hFF);
		rd_acc(32'h0000017D);
		// Reset in mid-run clears everything again
		smac_cpu_model_i.idle();
		srst = 1'b1;
		smac_cpu_model_i.idle();
		srst = 1'b0;
		for (int a = 'hE8; a <= 'hEF; a++)
			rd(8'(a), `SMAC_RST_BYTE);
		smac_cpu_model_i.idle();
		print_verdict();
	end
endmodule : testbench
